// *** verilog/cac_pkg.sv ***
// Package with register map, field layout, reset values and carrier types for the channel A register bank
package cac_pkg;

  // Register offsets on the slave register port
  localparam logic [7:0] CAC_OFS_MUTE  = 8'h0e;
  localparam logic [7:0] CAC_OFS_EQ    = 8'h0f;
  localparam logic [7:0] CAC_OFS_CTL1  = 8'h10;
  localparam logic [7:0] CAC_OFS_CTL2  = 8'h11;
  localparam logic [7:0] CAC_OFS_THR   = 8'h12;
  localparam logic [7:0] CAC_OFS_BOV1  = 8'h13;
  localparam logic [7:0] CAC_OFS_BSPR  = 8'h14;

  // Values after reset
  localparam logic [7:0] CAC_RST_MUTE  = 8'h00;
  localparam logic [7:0] CAC_RST_EQ    = 8'h2f;
  localparam logic [7:0] CAC_RST_CTL1  = 8'hed;
  localparam logic [7:0] CAC_RST_CTL2  = 8'h82;
  localparam logic [7:0] CAC_RST_THR   = 8'h00;
  localparam logic [7:0] CAC_RST_BOV1  = 8'h00;
  localparam logic [7:0] CAC_RST_BSPR  = 8'h00;

  // Field positions
  localparam int CAC_BIT_MANUAL   = 5;
  localparam int CAC_BIT_MUTESEL  = 4;
  localparam int CAC_BIT_SCP      = 7;
  localparam int CAC_BIT_MODE     = 6;
  localparam int CAC_DEM_LSB      = 0;
  localparam int CAC_CTL2_RO_LSB  = 5;
  localparam int CAC_ASRT_LSB     = 2;
  localparam int CAC_DASRT_LSB    = 0;
  localparam int CAC_OVR_THR      = 6;
  localparam int CAC_OVR_IDLE     = 4;
  localparam int CAC_OVR_MODE     = 2;

  // Mask of the writable bits in control two
  localparam logic [7:0] CAC_CTL2_WMASK = 8'h1f;

  // Defaults that the outputs take at reset, and the register count
  localparam logic [2:0] CAC_DEM_DEFAULT = 3'h2;
  localparam logic [1:0] CAC_THR_DEFAULT = 2'h0;
  localparam int         CAC_NUM_REGS    = 7;

  // Register write request from the slave port
  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } cac_wreq_s;

  // Shared control bits from neighbouring registers
  typedef struct packed {
    logic ovrIdle;
    logic ovrThr;
    logic ovrMode;
    logic regEnable;
  } cac_ovr_s;

  // Conditioning settings handed to the analog channel
  typedef struct packed {
    logic       idleAuto;
    logic       idleForce;
    logic       useRegIdle;
    logic [7:0] eqBoost;
    logic       scpEnable;
    logic       normalMode;
    logic [2:0] deemphasisLevel;
    logic [1:0] assertThr;
    logic [1:0] deassertThr;
    logic       useRegThr;
  } cac_cond_s;

  // Automatic or manual idle selection
  typedef enum logic [0:0] {
    CAC_IDLE_AUTO   = 1'b0,
    CAC_IDLE_MANUAL = 1'b1
  } cac_idle_e;

endpackage

// *** verilog/cac_reg_cell.sv ***
// One eight-bit register with reset value, write mask and address match
`timescale 1ns/100ps
module cac_reg_cell #(
  parameter logic [7:0] ADDR  = 8'h00,
  parameter logic [7:0] RESET = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire cac_pkg::cac_wreq_s wreq,
  output logic [7:0]            value
);

  // Masked bits hold their reset value; write to them is ignored
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      value <= RESET;
    end else if (wreq.wrEn && wreq.addr == ADDR) begin
      value <= (wreq.data & WMASK) | (RESET & ~WMASK);
    end
  end

endmodule // cac_reg_cell

// *** verilog/cac_channel_regs.sv ***
// Channel A conditioning register bank with override gating of its settings except scpEnable
`timescale 1ns/100ps
module cac_channel_regs (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire cac_pkg::cac_wreq_s wreq,
  input  wire logic [7:0]         rdAddr,
  input  wire cac_pkg::cac_ovr_s  ovr,
  input  wire logic [1:0]         signalDetectThresholdPin,
  output cac_pkg::cac_cond_s      cond,
  output logic [7:0]              rdData,
  output logic                    rdHit
);

  localparam logic [7:0] ADDRS  [cac_pkg::CAC_NUM_REGS] = '{
    cac_pkg::CAC_OFS_MUTE, cac_pkg::CAC_OFS_EQ, cac_pkg::CAC_OFS_CTL1, cac_pkg::CAC_OFS_CTL2,
    cac_pkg::CAC_OFS_THR, cac_pkg::CAC_OFS_BOV1, cac_pkg::CAC_OFS_BSPR};
  localparam logic [7:0] RESETS [cac_pkg::CAC_NUM_REGS] = '{
    cac_pkg::CAC_RST_MUTE, cac_pkg::CAC_RST_EQ, cac_pkg::CAC_RST_CTL1, cac_pkg::CAC_RST_CTL2,
    cac_pkg::CAC_RST_THR, cac_pkg::CAC_RST_BOV1, cac_pkg::CAC_RST_BSPR};
  localparam logic [7:0] MASKS  [cac_pkg::CAC_NUM_REGS] = '{
    8'hff, 8'hff, 8'hff, cac_pkg::CAC_CTL2_WMASK, 8'hff, 8'hff, 8'hff};

  logic [7:0] regVal [cac_pkg::CAC_NUM_REGS]; // Register contents by index
  logic [1:0] pinMeta_r;                       // First stage, read only by second
  logic [1:0] pinSync_r;                       // Second stage of threshold pin
  logic [7:0] eqApplied_r;                     // Analog settings latched under enable
  logic [2:0] demApplied_r;

  // One register cell per map entry
  genvar gi;
  generate
    for (gi = 0; gi < cac_pkg::CAC_NUM_REGS; gi++) begin : g_reg
      cac_reg_cell #(
        .ADDR  (ADDRS[gi]),
        .RESET (RESETS[gi]),
        .WMASK (MASKS[gi])
      ) u_cell (
        .clk_sys (clk_sys),
        .reset   (reset),
        .wreq    (wreq),
        .value   (regVal[gi])
      );
    end
  endgenerate

  // Threshold pin comes from outside, so it passes two flip-flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pinMeta_r <= 2'h0;
      pinSync_r <= 2'h0;
    end else begin
      pinMeta_r <= signalDetectThresholdPin;
      pinSync_r <= pinMeta_r;
    end
  end

  // Equalizer and de-emphasis only move while register control is enabled
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      eqApplied_r  <= cac_pkg::CAC_RST_EQ;
      demApplied_r <= cac_pkg::CAC_DEM_DEFAULT;
    end else if (ovr.regEnable) begin
      eqApplied_r  <= regVal[1];
      demApplied_r <= regVal[3][cac_pkg::CAC_DEM_LSB +: 3];
    end
  end

  // Settings to the analog channel, registered so outputs leave flip-flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cond <= '0;
      cond.idleAuto        <= 1'b1;
      cond.eqBoost         <= cac_pkg::CAC_RST_EQ;
      cond.scpEnable       <= cac_pkg::CAC_RST_CTL1[cac_pkg::CAC_BIT_SCP];
      cond.normalMode      <= 1'b1;
      cond.deemphasisLevel <= cac_pkg::CAC_DEM_DEFAULT;
      cond.assertThr       <= cac_pkg::CAC_THR_DEFAULT;
      cond.deassertThr     <= cac_pkg::CAC_THR_DEFAULT;
    end else begin
      cond.useRegIdle <= ovr.ovrIdle;
      // Manual bit decides whether bit 4 is honoured
      cond.idleAuto   <= !(ovr.ovrIdle && regVal[0][cac_pkg::CAC_BIT_MANUAL]);
      cond.idleForce  <= ovr.ovrIdle && regVal[0][cac_pkg::CAC_BIT_MANUAL]
                         && regVal[0][cac_pkg::CAC_BIT_MUTESEL];
      cond.eqBoost    <= eqApplied_r;
      cond.scpEnable  <= regVal[2][cac_pkg::CAC_BIT_SCP];
      // Without mode override the output stays normal
      cond.normalMode <= ovr.ovrMode ? regVal[2][cac_pkg::CAC_BIT_MODE] : 1'b1;
      cond.deemphasisLevel <= demApplied_r;
      cond.useRegThr  <= ovr.ovrThr;
      if (ovr.ovrThr) begin
        cond.assertThr   <= regVal[4][cac_pkg::CAC_ASRT_LSB +: 2];
        cond.deassertThr <= regVal[4][cac_pkg::CAC_DASRT_LSB +: 2];
      end else begin
        // Pin code drives both thresholds when not overridden
        cond.assertThr   <= pinSync_r;
        cond.deassertThr <= pinSync_r;
      end
    end
  end

  // Read mux, registered; unmapped offsets read zero with no hit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData <= 8'h00;
      rdHit  <= 1'b0;
    end else begin
      rdData <= 8'h00;
      rdHit  <= 1'b0;
      for (int i = 0; i < cac_pkg::CAC_NUM_REGS; i++) begin
        if (rdAddr == ADDRS[i]) begin
          rdData <= regVal[i];
          rdHit  <= 1'b1;
        end
      end
    end
  end

endmodule // cac_channel_regs

// *** tb/cac_host_model.sv ***
// Host side model that writes the channel registers and the shared override bits
`timescale 1ns/100ps
module cac_host_model (
  input  wire logic          clk_sys,
  output cac_pkg::cac_wreq_s wreq,
  output cac_pkg::cac_ovr_s  ovr
);
  // Idle bus and all overrides off until the bench asks
  initial wreq = '0;
  initial ovr = '0;
  // Strobe stays up so back-to-back writes need no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wreq = {1'b1, a, d};
    @(negedge clk_sys);
  endtask
  // Override and enable bits set before mute, threshold or analog writes
  task automatic setOvr(input cac_pkg::cac_ovr_s o);
    ovr = o;
  endtask
  // Drop the strobe, then idle for n cycles
  task automatic rest(input int n);
    wreq.wrEn = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask
endmodule // cac_host_model

// *** tb/cac_channel_regs_properties.sv ***
// Port assertions for the channel A register bank
`timescale 1ns/100ps
module cac_channel_regs_properties (
  input wire logic               clk_sys,
  input wire logic               reset,
  input wire cac_pkg::cac_wreq_s wreq,
  input wire logic [7:0]         rdAddr,
  input wire cac_pkg::cac_ovr_s  ovr,
  input wire logic [1:0]         signalDetectThresholdPin,
  input wire cac_pkg::cac_cond_s cond,
  input wire logic [7:0]         rdData,
  input wire logic               rdHit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // A write to one offset
  sequence s_wr(logic [7:0] ofs);
    wreq.wrEn && wreq.addr == ofs;
  endsequence
  // Analog write with register enable held through the two-stage apply
  sequence s_apply(logic [7:0] ofs);
    s_wr(ofs) ##0 ovr.regEnable ##1 ovr.regEnable [*2];
  endsequence
  property p_eq;
    s_apply(cac_pkg::CAC_OFS_EQ) |=> cond.eqBoost == $past(wreq.data, 3);
  endproperty
  a_eq: assert property (p_eq) else $error("eq boost not applied");
  property p_dem;
    s_apply(cac_pkg::CAC_OFS_CTL2) |=> cond.deemphasisLevel == $past(wreq.data[2:0], 3);
  endproperty
  a_dem: assert property (p_dem) else $error("de-emphasis not applied");
  property p_scp;
    s_wr(cac_pkg::CAC_OFS_CTL1) |-> ##2 cond.scpEnable == $past(wreq.data[7], 2);
  endproperty
  a_scp: assert property (p_scp) else $error("short protection wrong");
  property p_mode;
    s_wr(cac_pkg::CAC_OFS_CTL1) ##0 ovr.ovrMode ##1 ovr.ovrMode |=> cond.normalMode == $past(wreq.data[6], 2);
  endproperty
  a_mode: assert property (p_mode) else $error("output mode wrong");
  property p_mute;
    s_wr(cac_pkg::CAC_OFS_MUTE) ##0 ovr.ovrIdle ##1 ovr.ovrIdle |=>
      cond.idleForce == ($past(wreq.data[5], 2) && $past(wreq.data[4], 2));
  endproperty
  a_mute: assert property (p_mute) else $error("mute control wrong");
  property p_thr;
    s_wr(cac_pkg::CAC_OFS_THR) ##0 ovr.ovrThr ##1 ovr.ovrThr |=>
      {cond.assertThr, cond.deassertThr} == $past(wreq.data[3:0], 2);
  endproperty
  a_thr: assert property (p_thr) else $error("thresholds wrong");
  property p_ctl2rd;
    rdAddr == cac_pkg::CAC_OFS_CTL2 |=> rdHit && rdData[7:5] == 3'h4;
  endproperty
  a_ctl2rd: assert property (p_ctl2rd) else $error("control two top bits changed");
  property p_unmap;
    !(rdAddr inside {[8'h0e:8'h14]}) |=> !rdHit && rdData == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
endmodule // cac_channel_regs_properties
bind cac_channel_regs cac_channel_regs_properties props_i (.clk_sys(clk_sys), .reset(reset), .wreq(wreq),
  .rdAddr(rdAddr), .ovr(ovr), .signalDetectThresholdPin(signalDetectThresholdPin), .cond(cond),
  .rdData(rdData), .rdHit(rdHit));

// *** tb/tb_cac_channel_regs.sv ***
// Self-checking bench for the channel A register bank
`timescale 1ns/100ps
module tb_cac_channel_regs;
  logic               clk_sys, reset, rdHit;
  logic [7:0]         rdAddr, rdData;
  logic [1:0]         pin;
  int                 n_errors, checked;
  cac_pkg::cac_wreq_s wreq;
  cac_pkg::cac_ovr_s  ovr;
  cac_pkg::cac_cond_s cond;
  // Reset values, offsets 0x0e to 0x14
  logic [7:0] rstVal [7] = '{8'h00, 8'h2f, 8'hed, 8'h82, 8'h00, 8'h00, 8'h00};
  cac_host_model host_i (.clk_sys(clk_sys), .wreq(wreq), .ovr(ovr));
  cac_channel_regs cac_channel_regs_i (.clk_sys(clk_sys), .reset(reset), .wreq(wreq), .rdAddr(rdAddr),
    .ovr(ovr), .signalDetectThresholdPin(pin), .cond(cond), .rdData(rdData), .rdHit(rdHit));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Offset goes out at a falling edge, answer is settled one falling edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    rdAddr = a;
    @(negedge clk_sys);
    chk(rdData, exp);
    chk({7'h0, rdHit}, {7'h0, hit});
  endtask
  task automatic close_out();
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    rdAddr = 8'h00;
    pin = 2'h0;
    n_errors = 0;
    checked = 0;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    for (int i = 0; i < 7; i++) rd(8'h0e + 8'(i), rstVal[i], 1'b1);
    rd(8'h0d, 8'h00, 1'b0);
    rd(8'h15, 8'h00, 1'b0);
    host_i.wr(8'h11, 8'hff);
    host_i.rest(1);
    rd(8'h11, 8'h9f, 1'b1);
    host_i.setOvr(4'hf);
    host_i.wr(8'h0e, 8'h30);
    host_i.wr(8'h0f, 8'h40);
    host_i.wr(8'h10, 8'h2d);
    host_i.wr(8'h12, 8'h0b);
    host_i.rest(4);
    chk({6'h0, cond.idleAuto, cond.idleForce}, 8'h01);
    chk({7'h0, cond.useRegIdle}, 8'h01);
    chk(cond.eqBoost, 8'h40);
    chk({6'h0, cond.scpEnable, cond.normalMode}, 8'h00);
    chk({4'h0, cond.assertThr, cond.deassertThr}, 8'h0b);
    for (int c = 0; c < 8; c++) begin
      host_i.wr(8'h11, {5'h0, 3'(c)});
      host_i.rest(4);
      chk({5'h0, cond.deemphasisLevel}, {5'h0, 3'(c)});
    end
    pin = 2'h2;
    host_i.setOvr(4'h1);
    host_i.rest(6);
    chk({cond.useRegThr, cond.normalMode, cond.idleAuto, cond.idleForce, cond.assertThr, cond.deassertThr},
      8'h6a);
    chk({7'h0, cond.useRegIdle}, 8'h00);
    reset = 1'b1;
    host_i.rest(2);
    reset = 1'b0;
    rd(8'h0f, 8'h2f, 1'b1);
    close_out();
  end
endmodule // tb_cac_channel_regs
